// file: logic/ccs_pkg.sv
// Constants and types for the colour channel select control block
// Function
// RQ1 - Line mode powers down green/blue, forces mono
// RQ2 - Controller rewrites mono select between sensor lines
// RQ3 - Mono input chosen by setup-three bits 7:6
// RQ4 - Autocycle pulses advance muxes in line mode
// RQ5 - Muxes switch first clock after pin rises
// RQ6 - No force, no cycle: all from colour select
// RQ7 - No force, cycle: all step red-green-blue-red
// RQ8 - Force, no cycle: input forced, gain from select
// RQ9 - Force, cycle: input forced, gain/offset cycle
// RQ10 - Output timing identical with or without CDS
// RQ11 - Controller keeps clock ratios per mode
// RQ12 - No CDS in max speed; fast mode clears 5:4
// RQ13 - Controller sets max-speed flag only in mode four
// RQ14 - Sample taken first edge after strobe falls
package ccs_pkg;
    localparam logic [1:0] CCS_RED     = 2'h0;
    localparam logic [1:0] CCS_GREEN   = 2'h1;
    localparam logic [1:0] CCS_BLUE    = 2'h2;
    localparam logic [1:0] CCS_SEL_RST = 2'h0;
    localparam int         CCS_MONO_HI = 7;
    localparam int         CCS_MONO_LO = 6;
    localparam int         CCS_SEL_WIDTH    = 2;
    localparam int         CCS_COLOUR_COUNT = 3;
    localparam logic       CCS_FLAG_RST     = 1'h0;
    localparam logic [1:0] CCS_MODE_INTERNAL    = 2'h0;
    localparam logic [1:0] CCS_MODE_CYCLE       = 2'h1;
    localparam logic [1:0] CCS_MODE_FORCE       = 2'h2;
    localparam logic [1:0] CCS_MODE_FORCE_CYCLE = 2'h3;
    typedef enum logic [2:0] {
        CCS_CYC_RED   = 3'h1,
        CCS_CYC_GREEN = 3'h2,
        CCS_CYC_BLUE  = 3'h4
    } ccs_cycle_t;
    localparam ccs_cycle_t CCS_CYC_RST = CCS_CYC_RED;
endpackage : ccs_pkg

// file: logic/ccs_colour_select.sv
// Channel selection and line-by-line mode control
`timescale 1ns/100ps
`default_nettype none
module ccs_colour_select
    import ccs_pkg::*;
#(
    parameter int SEL_WIDTH    = CCS_SEL_WIDTH,
    parameter int COLOUR_COUNT = CCS_COLOUR_COUNT
)
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       colourLineSequentialEnable,
    input  wire logic       monoEnable,
    input  wire logic [7:0] thirdSetupRegister,
    input  wire logic       autocyclePinFunctionSelect,
    input  wire logic       clampOrAutocyclePin,
    input  wire logic       autocycleReset,
    input  wire logic [1:0] internalColourSelect,
    input  wire logic       forceInputMuxEnable,
    input  wire logic [1:0] forcedInputMuxSelect,
    input  wire logic       pixelSampleStrobe,
    output logic [1:0]      inputMuxSelect,
    output logic [1:0]      gainOffsetSelect,
    output logic            monoActive,
    output logic            greenPowerDown,
    output logic            bluePowerDown,
    output logic            clampRequest,
    output logic            sampleTake
);

    // Logic serves two-bit selects over three colours only
    generate
        if (SEL_WIDTH != CCS_SEL_WIDTH || COLOUR_COUNT != CCS_COLOUR_COUNT) begin : gBadParams
            $error("ccs_colour_select serves two-bit selects and three colours only");
        end
    endgenerate

    ccs_cycle_t cycle_reg;
    ccs_cycle_t cycle_next;
    logic       acycPrev_reg;
    logic       strobePrev_reg;
    logic [1:0] inSel_reg;
    logic [1:0] inSel_next;
    logic [1:0] goSel_reg;
    logic [1:0] goSel_next;
    logic       mono_reg;
    logic       mono_next;
    logic       gpd_reg;
    logic       bpd_reg;
    logic       powerDown_next;
    logic       take_reg;
    logic       take_next;
    logic       autoOn;
    logic       acycRise;
    logic       strobeFall;
    logic [1:0] cycleColour;
    logic [1:0] monoSelect;
    logic [1:0] muxMode;

    function automatic ccs_cycle_t cycleStep(input ccs_cycle_t c);
        case (c)
            CCS_CYC_RED:   cycleStep = CCS_CYC_GREEN;
            CCS_CYC_GREEN: cycleStep = CCS_CYC_BLUE;
            default:       cycleStep = CCS_CYC_RED;
        endcase
    endfunction : cycleStep

    function automatic logic [1:0] cycleCode(input ccs_cycle_t c);
        case (c)
            CCS_CYC_GREEN: cycleCode = CCS_GREEN;
            CCS_CYC_BLUE:  cycleCode = CCS_BLUE;
            default:       cycleCode = CCS_RED;
        endcase
    endfunction : cycleCode

    assign autoOn     = colourLineSequentialEnable && autocyclePinFunctionSelect; // RQ4
    assign acycRise   = clampOrAutocyclePin && !acycPrev_reg;
    assign strobeFall = strobePrev_reg && !pixelSampleStrobe;
    // Pin acts as clamp request when not in autocycle use
    assign clampRequest = clampOrAutocyclePin && !autoOn;

    // Previous pin level, idle low so no false edge after reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acycPrev_reg <= CCS_FLAG_RST;
        end else begin
            acycPrev_reg <= clampOrAutocyclePin;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            strobePrev_reg <= CCS_FLAG_RST;
        end else begin
            strobePrev_reg <= pixelSampleStrobe;
        end
    end

    // Cycle pointer steps on the first edge after the pin rises
    always_comb begin
        cycle_next = cycle_reg;
        if (autocycleReset) begin
            cycle_next = CCS_CYC_RED;
        end else if (autoOn && acycRise) begin
            cycle_next = cycleStep(cycle_reg); // RQ5 RQ7 RQ9
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cycle_reg <= CCS_CYC_RST;
        end else begin
            cycle_reg <= cycle_next;
        end
    end

    // Colour shown by the selects already on the stepping edge
    assign cycleColour = cycleCode(cycle_next);
    assign monoSelect  = thirdSetupRegister[CCS_MONO_HI:CCS_MONO_LO]; // RQ3
    assign muxMode     = {forceInputMuxEnable, autocyclePinFunctionSelect};

    always_comb begin
        inSel_next = monoSelect; // RQ3
        goSel_next = monoSelect;
        if (colourLineSequentialEnable) begin
            case (muxMode)
                CCS_MODE_INTERNAL: begin
                    inSel_next = internalColourSelect; // RQ6
                    goSel_next = internalColourSelect; // RQ6
                end
                CCS_MODE_CYCLE: begin
                    inSel_next = cycleColour; // RQ4 RQ7
                    goSel_next = cycleColour; // RQ7
                end
                CCS_MODE_FORCE: begin
                    inSel_next = forcedInputMuxSelect; // RQ8
                    goSel_next = internalColourSelect; // RQ8
                end
                CCS_MODE_FORCE_CYCLE: begin
                    inSel_next = forcedInputMuxSelect; // RQ9
                    goSel_next = cycleColour; // RQ9
                end
                default: begin
                    inSel_next = internalColourSelect;
                    goSel_next = internalColourSelect;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            inSel_reg <= CCS_SEL_RST;
        end else begin
            inSel_reg <= inSel_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            goSel_reg <= CCS_SEL_RST;
        end else begin
            goSel_reg <= goSel_next;
        end
    end

    // Line mode forces mono and parks green and blue
    always_comb begin
        mono_next      = monoEnable || colourLineSequentialEnable; // RQ1
        powerDown_next = colourLineSequentialEnable; // RQ1
        // Same strobe-to-sample timing whatever the CDS setting
        take_next      = strobeFall; // RQ14 RQ10
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mono_reg <= CCS_FLAG_RST;
        end else begin
            mono_reg <= mono_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gpd_reg <= CCS_FLAG_RST;
        end else begin
            gpd_reg <= powerDown_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bpd_reg <= CCS_FLAG_RST;
        end else begin
            bpd_reg <= powerDown_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            take_reg <= CCS_FLAG_RST;
        end else begin
            take_reg <= take_next;
        end
    end

    assign inputMuxSelect   = inSel_reg;
    assign gainOffsetSelect = goSel_reg;
    assign monoActive       = mono_reg;
    assign greenPowerDown   = gpd_reg;
    assign bluePowerDown    = bpd_reg;
    assign sampleTake       = take_reg;
endmodule : ccs_colour_select
`default_nettype wire

// file: dv/ccs_scan_ctrl.sv
// Scanner controller model: strobe every RATIO clocks, pin follows step
`timescale 1ns/100ps
`default_nettype none
module ccs_scan_ctrl #(parameter int RATIO = 6) (
    input  wire logic clock, step,
    output logic      pixelSampleStrobe = 1'h0, clampOrAutocyclePin = 1'h0
);
    int cnt = 0;
    always @(posedge clock) cnt <= (cnt + 1) % RATIO;
    always @(posedge clock) pixelSampleStrobe <= (cnt == 0);
    always @(posedge clock) clampOrAutocyclePin <= step;
endmodule : ccs_scan_ctrl
`default_nettype wire

// file: dv/ccs_assertions.sv
// Concurrent checks on the colour select block
`timescale 1ns/100ps
`default_nettype none
module ccs_checker (
    input wire logic clock, rst_n, colourLineSequentialEnable, autocyclePinFunctionSelect,
    input wire logic clampOrAutocyclePin, forceInputMuxEnable, pixelSampleStrobe, sampleTake,
    input wire logic greenPowerDown, bluePowerDown, monoActive,
    input wire logic [1:0] internalColourSelect, forcedInputMuxSelect,
    input wire logic [1:0] inputMuxSelect, gainOffsetSelect
);
    wire lm = colourLineSequentialEnable, fm = forceInputMuxEnable, p = clampOrAutocyclePin;
    wire cy = lm && autocyclePinFunctionSelect, rm = lm && !autocyclePinFunctionSelect;
    wire [1:0] g = gainOffsetSelect, m = inputMuxSelect, ic = internalColourSelect;
    wire [1:0] fs = forcedInputMuxSelect, gn = (g > 2'h1) ? 2'h0 : g + 2'h1;
    wire pd = greenPowerDown && bluePowerDown && monoActive;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    line_pwr_a: assert property (lm[*3] |-> pd) else $error("no powerdown");
    int_mux_a: assert property ((rm && !fm && $stable(ic))[*3] |-> m == ic) else $error("mux");
    int_gain_a: assert property ((rm && $stable(ic))[*3] |-> g == ic) else $error("gain");
    frc_mux_a: assert property ((lm && fm && $stable(fs))[*3] |-> m == fs) else $error("force");
    cyc_step_a: assert property (cy && $rose(p) |=> g == $past(gn)) else $error("step");
    one_step_a: assert property ((cy && p)[*2] |=> $stable(g)) else $error("hold");
    take_now_a: assert property ($fell(pixelSampleStrobe) |=> sampleTake) else $error("take");
    take_only_a: assert property (!$fell(pixelSampleStrobe) |=> !sampleTake) else $error("extra");
    cover property (cy && $rose(p));
    cover property (cy && fm && $rose(p));
    cover property (sampleTake);
endmodule : ccs_checker
bind ccs_colour_select ccs_checker chk (.*);
`default_nettype wire

// file: dv/test_colour_channel_select_control.sv
// Bench for the colour select block
`timescale 1ns/100ps
`default_nettype none
module test_colour_channel_select_control import ccs_pkg::*; ;
    logic clock = 1'h0, rst_n = 1'h0, colourLineSequentialEnable = 1'h0, monoEnable = 1'h0;
    logic autocyclePinFunctionSelect = 1'h0, autocycleReset = 1'h0, forceInputMuxEnable = 1'h0;
    logic step = 1'h0, pixelSampleStrobe, clampOrAutocyclePin, monoActive, greenPowerDown;
    logic bluePowerDown, clampRequest, sampleTake;
    logic [7:0] thirdSetupRegister = 8'h1F;
    logic [1:0] internalColourSelect = 2'h0, forcedInputMuxSelect = CCS_BLUE;
    logic [1:0] inputMuxSelect, gainOffsetSelect, e;
    int mismatches = 0, checked = 0, cycles = 0, n;
    always #2 clock = ~clock;
    ccs_colour_select dut (.*);
    ccs_scan_ctrl scanner (.*);
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic final_report;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    task automatic sel_paths;
        for (int i = 0; i < 6; i++) begin
            @(posedge clock) thirdSetupRegister <= {i[1:0], 6'h1F};
            colourLineSequentialEnable <= (i > 2);
            internalColourSelect <= i[1:0] + 2'h1;
            repeat (3) @(posedge clock);
            #1 chk("sel", 8'({inputMuxSelect, gainOffsetSelect}), 8'((i > 2) ? (i + 1) % 4 * 5 : i * 5));
        end
        chk("pd", 8'({greenPowerDown, bluePowerDown, monoActive}), 8'h07);
        @(posedge clock) forceInputMuxEnable <= 1'h1;
        internalColourSelect <= CCS_GREEN;
        repeat (3) @(posedge clock);
        #1 chk("frc", 8'({inputMuxSelect, gainOffsetSelect}), 8'h09);
    endtask : sel_paths
    task automatic mono_clamp;
        @(posedge clock) colourLineSequentialEnable <= 1'h0;
        autocyclePinFunctionSelect <= 1'h0;
        monoEnable <= 1'h1;
        step <= 1'h1;
        repeat (3) @(posedge clock);
        #1 chk("clamp", 8'(clampRequest), 8'h01);
        chk("mono", 8'({greenPowerDown, bluePowerDown, monoActive}), 8'h01);
        chk("refuse", 8'({inputMuxSelect, gainOffsetSelect}), 8'h05);
        @(posedge clock) step <= 1'h0;
    endtask : mono_clamp
    task automatic cycle_sel(input logic f);
        @(posedge clock) forceInputMuxEnable <= f;
        autocyclePinFunctionSelect <= 1'h1;
        autocycleReset <= 1'h1;
        @(posedge clock) autocycleReset <= 1'h0;
        e = CCS_RED;
        repeat (4) begin
            @(posedge clock) step <= 1'h1;
            repeat (2) @(posedge clock);
            step <= 1'h0;
            repeat (4) @(posedge clock);
            e = (e == CCS_BLUE) ? CCS_RED : e + 2'h1;
            #1 chk("cyc", 8'({f ? CCS_BLUE : e, e}), 8'({inputMuxSelect, gainOffsetSelect}));
        end
    endtask : cycle_sel
    task automatic sample_rate;
        n = 0;
        repeat (60) @(posedge clock) #1 n += (sampleTake === 1'h1);
        chk("take", 8'(n), 8'h0A);
    endtask : sample_rate
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'h1;
        sel_paths;
        cycle_sel(1'h0);
        cycle_sel(1'h1);
        mono_clamp;
        sample_rate;
        final_report;
    end
    always @(posedge clock) if (++cycles == 1000) begin
        mismatches++;
        final_report;
    end
endmodule : test_colour_channel_select_control
`default_nettype wire
